// >>> pus_pkg.sv
// Constants and types for the power-up reset sequencer
package pus_pkg;

  localparam int unsigned CLK_HZ            = 50000000;
  localparam int unsigned CLK_PERIOD_NS     = 20;

  // Times in their own units
  localparam int unsigned KEY_FILTER_US     = 12700;
  localparam int unsigned POR_DELAY_US      = 128;
  localparam int unsigned CORE_SETTLE_NS    = 5000;
  localparam int unsigned PREREG_RAMP_US    = 400;
  localparam int unsigned MAIN_RAMP_US      = 2000;
  localparam int unsigned UV_FILTER_US      = 10;

  // Cycle counts derived from the clock rate (least times round up)
  localparam int unsigned KEY_FILTER_CYC    = (KEY_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int unsigned POR_DELAY_CYC     = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int unsigned CORE_SETTLE_CYC   = (CORE_SETTLE_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;
  localparam int unsigned UV_FILTER_CYC     = (UV_FILTER_US * 1000 + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS;

  localparam int unsigned CNT_W             = 20;
  localparam logic        PROT_EN_RESET     = 1'b1;

  typedef enum logic [2:0] {
    PUS_OFF     = 3'b000,
    PUS_SETTLE  = 3'b001,
    PUS_KEYFILT = 3'b010,
    PUS_PREREG  = 3'b011,
    PUS_MAINUP  = 3'b100,
    PUS_PORTIME = 3'b101,
    PUS_RUN     = 3'b110
  } pus_state_type;

endpackage

// >>> pus_timer.sv
// Down-counting interval timer with load and done flag
`timescale 1ns/100ps
module pus_timer
  import pus_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             run,
  output logic                  done
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_done;

  initial begin
    if (WIDTH < 2) $error("pus_timer width too small");
  end

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (load) begin
      next_count = load_value;
    end else if (run) begin
      if (count <= WIDTH'(1)) begin
        next_count = '0;
        next_done  = 1'b1;
      end else begin
        next_count = count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule

// >>> pus_sequencer.sv
// Power-up supply and reset sequencer top
`timescale 1ns/100ps

// Behaviour
// - Battery overvoltage shuts off drivers and regulators
// - Key rising enables internal regulators and references
// - Core settle delay, then key filter starts
// - Key filter expiry enables pre-regulator
// - Pre-regulator good enables main and protected
// - Main supply above threshold starts POR timer
// - Reset output low until POR timer expires
// - Filtered main undervoltage asserts reset until POR
// - Protected supply on at power-on, software-disableable
// - Battery switch buffer powered with main regulators
// - Every sleep-to-active transition gives power-on reset
// - Protected enable bit resets to one
module pus_sequencer
  import pus_pkg::*;
#(
  parameter int unsigned KEY_FILTER_CYCLES  = KEY_FILTER_CYC,
  parameter int unsigned POR_DELAY_CYCLES   = POR_DELAY_CYC,
  parameter int unsigned CORE_SETTLE_CYCLES = CORE_SETTLE_CYC,
  parameter int unsigned UV_FILTER_CYCLES   = UV_FILTER_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic key_switch_in,
  input  wire logic battery_overvoltage,
  input  wire logic preregulator_sense,
  input  wire logic main_supply_por_ok,
  input  wire logic main_supply_uv,
  input  wire logic protected_enable_write,
  input  wire logic protected_enable_data,
  output logic      internal_bias_enable,
  output logic      internal_poweron_reset_n,
  output logic      preregulator_enable,
  output logic      main_regulator_enable,
  output logic      protected_sensor_supply,
  output logic      battery_switch_enable,
  output logic      output_drivers_enable,
  output logic      mcu_reset_n_out
);

  initial begin
    if (KEY_FILTER_CYCLES < 1 || KEY_FILTER_CYCLES >= (1 << CNT_W)) begin
      $error("key filter count out of range");
    end
    if (POR_DELAY_CYCLES < 1 || POR_DELAY_CYCLES >= (1 << CNT_W)) begin
      $error("por delay count out of range");
    end
    if (CORE_SETTLE_CYCLES < 1 || CORE_SETTLE_CYCLES >= (1 << CNT_W)) begin
      $error("core settle count out of range");
    end
    if (UV_FILTER_CYCLES < 1 || UV_FILTER_CYCLES >= (1 << CNT_W)) begin
      $error("uv filter count out of range");
    end
  end

  // Reset release through two flops
  logic rst_sync_a;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_a <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_sync_a <= 1'b1;
      rst_sync_b <= rst_sync_a;
    end
  end

  pus_state_type state;
  pus_state_type next_state;
  logic          key_prev;
  logic          prot_enable;
  logic          next_prot_enable;
  logic          uv_count_active;
  logic [CNT_W-1:0] uv_count;
  logic [CNT_W-1:0] next_uv_count;
  logic          uv_fault;
  logic          next_uv_fault;

  logic          tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic          tmr_run;
  logic          tmr_done;

  // One shared timer; each timed phase (settle, key filter, POR) reloads it on entry
  pus_timer #(
    .WIDTH      (CNT_W)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_sync_b),
    .load       (tmr_load),
    .load_value (tmr_value),
    .run        (tmr_run),
    .done       (tmr_done)
  );

  wire key_rise = key_switch_in & ~key_prev;

  always_comb begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_value  = '0;
    tmr_run    = 1'b0;
    case (state)
      PUS_OFF: begin
        if (key_rise && !battery_overvoltage) begin
          next_state = PUS_SETTLE;
          tmr_load   = 1'b1;
          tmr_value  = CNT_W'(CORE_SETTLE_CYCLES);
        end
      end
      PUS_SETTLE: begin
        tmr_run = 1'b1;
        if (tmr_done) begin
          next_state = PUS_KEYFILT;
          tmr_load   = 1'b1;
          tmr_value  = CNT_W'(KEY_FILTER_CYCLES);
        end
      end
      PUS_KEYFILT: begin
        tmr_run = 1'b1;
        if (tmr_done) begin
          next_state = PUS_PREREG;
        end
      end
      PUS_PREREG: begin
        if (preregulator_sense) begin
          next_state = PUS_MAINUP;
        end
      end
      PUS_MAINUP: begin
        if (main_supply_por_ok) begin
          next_state = PUS_PORTIME;
          tmr_load   = 1'b1;
          tmr_value  = CNT_W'(POR_DELAY_CYCLES);
        end
      end
      PUS_PORTIME: begin
        tmr_run = 1'b1;
        if (!main_supply_por_ok) begin
          next_state = PUS_MAINUP;
        end else if (tmr_done) begin
          next_state = PUS_RUN;
        end
      end
      PUS_RUN: begin
        if (uv_fault) begin
          next_state = PUS_MAINUP;
        end
      end
      default: begin
        next_state = PUS_OFF;
      end
    endcase
    // Key low returns to sleep, so next wake repeats POR
    if (state != PUS_OFF && !key_switch_in) begin
      next_state = PUS_OFF;
      tmr_load   = 1'b1;
    end
    // Overvoltage wins over every phase
    if (battery_overvoltage) begin
      next_state = PUS_OFF;
      tmr_load   = 1'b1;
    end
  end

  // Undervoltage filter, active only once running
  always_comb begin
    uv_count_active = (state == PUS_RUN) && main_supply_uv;
    next_uv_count   = '0;
    next_uv_fault   = 1'b0;
    if (uv_count_active) begin
      if (uv_count >= CNT_W'(UV_FILTER_CYCLES)) begin
        next_uv_count = uv_count;
        next_uv_fault = 1'b1;
      end else begin
        next_uv_count = uv_count + CNT_W'(1);
      end
    end
  end

  // Protected supply enable; restored to on by every internal reset
  always_comb begin
    next_prot_enable = prot_enable;
    if (state == PUS_OFF) begin
      next_prot_enable = PROT_EN_RESET;
    end else if (protected_enable_write) begin
      next_prot_enable = protected_enable_data;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state       <= PUS_OFF;
      key_prev    <= 1'b0;
      prot_enable <= PROT_EN_RESET;
      uv_count    <= '0;
      uv_fault    <= 1'b0;
    end else begin
      state       <= next_state;
      key_prev    <= key_switch_in;
      prot_enable <= next_prot_enable;
      uv_count    <= next_uv_count;
      uv_fault    <= next_uv_fault;
    end
  end

  // Registered outputs
  logic next_bias;
  logic next_por_n;
  logic next_prereg;
  logic next_main;
  logic next_prot;
  logic next_batsw;
  logic next_drivers;
  logic next_mcu_rst_n;

  always_comb begin
    next_bias      = (next_state != PUS_OFF);
    next_por_n     = (next_state != PUS_OFF) && (next_state != PUS_SETTLE);
    next_prereg    = (next_state >= PUS_PREREG) && (next_state != PUS_OFF);
    next_main      = (next_state >= PUS_MAINUP);
    next_prot      = next_main && next_prot_enable;
    next_batsw     = next_main;
    next_mcu_rst_n = (next_state == PUS_RUN) && !next_uv_fault;
    next_drivers   = next_mcu_rst_n && !battery_overvoltage;
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      internal_bias_enable     <= 1'b0;
      internal_poweron_reset_n <= 1'b0;
      preregulator_enable      <= 1'b0;
      main_regulator_enable    <= 1'b0;
      protected_sensor_supply  <= 1'b0;
      battery_switch_enable    <= 1'b0;
      output_drivers_enable    <= 1'b0;
      mcu_reset_n_out          <= 1'b0;
    end else begin
      internal_bias_enable     <= next_bias;
      internal_poweron_reset_n <= next_por_n;
      preregulator_enable      <= next_prereg;
      main_regulator_enable    <= next_main;
      protected_sensor_supply  <= next_prot;
      battery_switch_enable    <= next_batsw;
      output_drivers_enable    <= next_drivers;
      mcu_reset_n_out          <= next_mcu_rst_n;
    end
  end

endmodule

// >>> pus_sequencer_properties.sv
// Port assertions for the power-up reset sequencer
`timescale 1ns/100ps
module pus_sequencer_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_switch_in,
  input wire logic battery_overvoltage,
  input wire logic preregulator_sense,
  input wire logic main_supply_por_ok,
  input wire logic main_supply_uv,
  input wire logic internal_bias_enable,
  input wire logic internal_poweron_reset_n,
  input wire logic preregulator_enable,
  input wire logic main_regulator_enable,
  input wire logic protected_sensor_supply,
  input wire logic battery_switch_enable,
  input wire logic mcu_reset_n_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_key_up;
    $rose(key_switch_in) && !battery_overvoltage && !internal_bias_enable;
  endsequence
  sequence s_sag;
    mcu_reset_n_out && main_supply_uv ##1 main_supply_uv [*7];
  endsequence
  property p_ov;
    battery_overvoltage |=> !(internal_bias_enable || preregulator_enable ||
      main_regulator_enable || protected_sensor_supply || mcu_reset_n_out);
  endproperty
  a_ov: assert property (p_ov) else $error("outputs on under overvoltage");
  property p_key; s_key_up |-> ##[1:2] internal_bias_enable; endproperty
  a_key: assert property (p_key) else $error("bias not enabled on key");
  property p_filt; $rose(preregulator_enable) |-> $past(internal_poweron_reset_n, 21); endproperty
  a_filt: assert property (p_filt) else $error("key filter cut short");
  property p_main; $rose(main_regulator_enable) |-> $past(preregulator_sense); endproperty
  a_main: assert property (p_main) else $error("main up without sense");
  property p_bsw; battery_switch_enable == main_regulator_enable; endproperty
  a_bsw: assert property (p_bsw) else $error("switch buffer apart from main");
  property p_prot; protected_sensor_supply |-> main_regulator_enable; endproperty
  a_prot: assert property (p_prot) else $error("protected rail without main");
  property p_por;
    $rose(mcu_reset_n_out) |-> main_supply_por_ok && $past(main_supply_por_ok, 12);
  endproperty
  a_por: assert property (p_por) else $error("reset released early");
  property p_sag; s_sag |=> !mcu_reset_n_out; endproperty
  a_sag: assert property (p_sag) else $error("reset kept high in sag");
  property p_new; $rose(internal_bias_enable) |-> !internal_poweron_reset_n; endproperty
  a_new: assert property (p_new) else $error("no fresh internal reset");
endmodule
bind pus_sequencer pus_sequencer_properties u_props (.*);

// >>> pus_far_side.sv
// Supply rail stand-in with selectable ramp time and sag
`timescale 1ns/100ps
module pus_far_side (
  input  wire logic       clk,
  input  wire logic       preregulator_enable,
  input  wire logic       main_regulator_enable,
  input  wire logic [7:0] ramp,
  input  wire logic       sag,
  output logic            preregulator_sense,
  output logic            main_supply_por_ok,
  output logic            main_supply_uv
);
  logic [7:0] pre_cnt = 8'h00;
  logic [7:0] main_cnt = 8'h00;
  // Saturate so a long run never wraps a rail back down
  always @(posedge clk) begin
    pre_cnt <= preregulator_enable ? pre_cnt + {7'h00, pre_cnt != 8'hFF} : 8'h00;
    main_cnt <= main_regulator_enable ? main_cnt + {7'h00, main_cnt != 8'hFF} : 8'h00;
  end
  assign preregulator_sense = preregulator_enable && pre_cnt >= ramp;
  assign main_supply_por_ok = main_regulator_enable && main_cnt >= ramp && !sag;
  assign main_supply_uv     = !main_supply_por_ok;
endmodule

// >>> pus_sequencer_tb.sv
// Self-checking bench for the power-up reset sequencer
`timescale 1ns/100ps
module pus_sequencer_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       key = 1'b0;
  logic       ov = 1'b0;
  logic       wr = 1'b0;
  logic       sag = 1'b0;
  logic       wd = 1'b0;
  logic [7:0] ramp = 8'h00;
  logic       sense;
  logic       pok;
  logic       uv;
  wire  [7:0] o;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         n = 0;
  pus_sequencer #(.KEY_FILTER_CYCLES(20), .POR_DELAY_CYCLES(10), .CORE_SETTLE_CYCLES(3),
    .UV_FILTER_CYCLES(5)) dut (.clk(clk), .rst_n(rst_n), .key_switch_in(key),
    .battery_overvoltage(ov), .preregulator_sense(sense), .main_supply_por_ok(pok),
    .main_supply_uv(uv), .protected_enable_write(wr), .protected_enable_data(wd),
    .internal_bias_enable(o[7]), .internal_poweron_reset_n(o[6]),
    .preregulator_enable(o[5]), .main_regulator_enable(o[4]),
    .protected_sensor_supply(o[3]), .battery_switch_enable(o[2]),
    .output_drivers_enable(o[1]), .mcu_reset_n_out(o[0]));
  pus_far_side far (.clk(clk), .preregulator_enable(o[5]), .main_regulator_enable(o[4]),
    .ramp(ramp), .sag(sag), .preregulator_sense(sense), .main_supply_por_ok(pok),
    .main_supply_uv(uv));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e);
    total_checks++;
    if (o !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, o);
      n_fail++;
    end
  endtask
  task automatic chkn(input string nm, input int lo);
    total_checks++;
    if (n < lo) begin
      $display("[FAIL] %s expected >=%0d seen %0d", nm, lo, n);
      n_fail++;
    end
  endtask
  // Bounded wait on one output bit, counting falling edges in n
  task automatic wt(input int b);
    n = 0;
    while (o[b] !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_up;
    key = 1'b1;
    wt(5);
    chk("prereg", 8'hE0);
    chkn("filter", 23);
    wt(4);
    chk("main", 8'hFC);
    wt(0);
    chk("run", 8'hFF);
    chkn("por", 10);
  endtask
  task automatic t_prot_uv;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    repeat (2) @(negedge clk);
    chk("prot off", 8'hF7);
    sag = 1'b1;
    repeat (3) @(negedge clk);
    sag = 1'b0;
    repeat (3) @(negedge clk);
    chk("short sag", 8'hF7);
    sag = 1'b1;
    repeat (10) @(negedge clk);
    chk("long sag", 8'hF4);
    sag = 1'b0;
    repeat (5) @(negedge clk);
    // A dip in mid-timing must restart the reset delay
    sag = 1'b1;
    @(negedge clk);
    sag = 1'b0;
    wt(0);
    chk("recover", 8'hF7);
    chkn("recover por", 10);
    wd = 1'b1;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    wd = 1'b0;
    repeat (2) @(negedge clk);
    chk("prot on", 8'hFF);
  endtask
  task automatic t_ov;
    ov = 1'b1;
    @(negedge clk);
    chk("ov off", 8'h00);
    key = 1'b0;
    @(negedge clk);
    key = 1'b1;
    repeat (30) @(negedge clk);
    chk("ov key", 8'h00);
    ov = 1'b0;
    key = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic t_rst;
    key = 1'b1;
    wt(5);
    rst_n = 1'b0;
    @(negedge clk);
    chk("mid reset", 8'h00);
    rst_n = 1'b1;
    wt(7);
    chk("restart", 8'h80);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk("reset", 8'h00);
    repeat (4) @(negedge clk);
    t_up();
    t_prot_uv();
    key = 1'b0;
    repeat (3) @(negedge clk);
    chk("sleep", 8'h00);
    ramp = 8'h30;
    t_up();
    t_ov();
    t_rst();
    close_out();
  end
endmodule
